// >>> pvcu_pkg.sv
// constants shared by the pin verify/change unit
`default_nettype none
package pvcu_pkg;
    // ==========================================================
    // sizing
    localparam int          SLOTS        = 8;
    localparam int          SLOTS_MIN    = 4;
    localparam int          SLOTS_MAX    = 32;
    // ==========================================================
    // register byte offsets
    localparam logic [4:0]  OFF_CMD      = 5'h00;
    localparam logic [4:0]  OFF_STAT     = 5'h04;
    localparam logic [4:0]  OFF_DATA0    = 5'h08;
    localparam int          DATA_WORDS   = 4;
    localparam logic [4:0]  OFF_ACC      = 5'h18;
    localparam logic [4:0]  OFF_PROV     = 5'h1C;
    // ==========================================================
    // field positions
    localparam int          CMD_P2_LSB   = 0;
    localparam int          CMD_P1_LSB   = 8;
    localparam int          CMD_LC_LSB   = 16;
    localparam int          CMD_OP_BIT   = 24;
    localparam int          STAT_BUSY    = 16;
    localparam int          PROV_DIS_BIT = 8;
    localparam int          ACC_GRANT    = 2;
    localparam int          ACC_BLOCK    = 3;
    localparam int          ACC_DIS      = 4;
    localparam int          ACC_VER      = 5;
    localparam int          P2_SPEC_BIT  = 7;
    // ==========================================================
    // command coding
    localparam logic        OP_VERIFY    = 1'b0;
    localparam logic        OP_CHANGE    = 1'b1;
    localparam logic [7:0]  LC_QUERY     = 8'h00;
    localparam logic [7:0]  LC_VERIFY    = 8'h08;
    localparam logic [7:0]  LC_CHANGE    = 8'h10;
    localparam logic [1:0]  CTR_INIT     = 2'h3;
    // ==========================================================
    // status words
    localparam logic [15:0] SW_RESET     = 16'h0000;
    localparam logic [15:0] SW_OK        = 16'h9000;
    localparam logic [11:0] SW_RETRY_HI  = 12'h63C;
    localparam logic [15:0] SW_BLOCKED   = 16'h6983;
    localparam logic [15:0] SW_DISABLED  = 16'h6984;
    localparam logic [15:0] SW_BAD_P1P2  = 16'h6B00;
    localparam logic [15:0] SW_NO_REF    = 16'h6A88;
    localparam logic [15:0] SW_BAD_LC    = 16'h6700;
endpackage
`default_nettype wire

// >>> pvcu_nv_store.sv
// retained pin values, attempt counters and disabled flags
`default_nettype none
module pvcu_nv_store #(
    parameter int SLOTS = pvcu_pkg::SLOTS
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_nv_erase_n,
    input  wire logic                     i_we,
    input  wire logic [$clog2(SLOTS)-1:0] i_slot,
    input  wire logic [1:0]               i_ctr,
    input  wire logic                     i_pin_we,
    input  wire logic [63:0]              i_pin,
    input  wire logic                     i_dis_we,
    input  wire logic                     i_dis,
    input  wire logic [$clog2(SLOTS)-1:0] i_qslot,
    output logic      [63:0]              o_pin,
    output logic      [1:0]               o_ctr,
    output logic                          o_dis,
    output logic      [1:0]               o_qctr,
    output logic                          o_qdis
);
    typedef struct packed {
        logic [SLOTS-1:0][63:0] pin;
        logic [SLOTS-1:0][1:0]  ctr;
        logic [SLOTS-1:0]       dis;
    } pvcu_nv_t;

    pvcu_nv_t q;
    pvcu_nv_t d;

    // ==========================================================
    // update
    always_comb
    begin
        d = q;
        if (i_we)
        begin
            d.ctr[i_slot] = i_ctr;
            if (i_pin_we)
                d.pin[i_slot] = i_pin;
            if (i_dis_we)
                d.dis[i_slot] = i_dis;
        end
    end

    // session reset never reaches here: counters outlive power loss
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nv_erase_n)
        begin
            q.pin <= '0;
            q.ctr <= {SLOTS{pvcu_pkg::CTR_INIT}};
            q.dis <= '0;
        end
        else
            q <= d;
    end

    assign o_pin  = q.pin[i_slot];
    assign o_ctr  = q.ctr[i_slot];
    assign o_dis  = q.dis[i_slot];
    assign o_qctr = q.ctr[i_qslot];
    assign o_qdis = q.dis[i_qslot];
endmodule
`default_nettype wire

// >>> pvcu_sec_status.sv
// session security status shared by all logical channels
`default_nettype none
module pvcu_sec_status #(
    parameter int SLOTS = pvcu_pkg::SLOTS
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_set,
    input  wire logic                     i_clr,
    input  wire logic [$clog2(SLOTS)-1:0] i_slot,
    input  wire logic [$clog2(SLOTS)-1:0] i_qslot,
    input  wire logic                     i_qdis,
    input  wire logic                     i_qblk,
    output logic                          o_qver,
    output logic                          o_qgrant
);
    typedef struct packed {
        logic [SLOTS-1:0] ver;
    } pvcu_sec_t;

    pvcu_sec_t q;
    pvcu_sec_t d;

    // ==========================================================
    // one flag per pin, no channel index: status is card-wide
    always_comb
    begin
        d = q;
        if (i_clr)
            d.ver[i_slot] = 1'b0;
        if (i_set)
            d.ver[i_slot] = 1'b1;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            q.ver <= '0;
        else
            q <= d;
    end

    assign o_qver   = q.ver[i_qslot];
    // disabled pin passes even if blocked; a blocked pin that is not disabled never does
    assign o_qgrant = i_qdis | (q.ver[i_qslot] & ~i_qblk);
endmodule
`default_nettype wire

// >>> pvcu_top.sv
// pin verify/change command unit with avalon-mm register slave
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
module pvcu_top #(
    parameter int SLOTS = pvcu_pkg::SLOTS
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_nv_erase_n,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest
);
    localparam int SB   = $clog2(SLOTS);
    localparam int HALF = SLOTS / 2;

    // ==========================================================
    // parameter check
    if (SLOTS < pvcu_pkg::SLOTS_MIN || SLOTS > pvcu_pkg::SLOTS_MAX
        || (SLOTS & (SLOTS - 1)) != 0)
    begin : g_bad_slots
        $error("pvcu_top: SLOTS must be a power of two from 4 to 32");
    end

    typedef enum logic {ST_IDLE, ST_EXEC} pvcu_state_t;

    typedef struct packed {
        pvcu_state_t                              st;
        logic                                     wrq;
        logic [31:0]                              rdata;
        logic [7:0]                               p1;
        logic [7:0]                               p2;
        logic [7:0]                               lc;
        logic                                     op;
        logic [pvcu_pkg::DATA_WORDS-1:0][31:0]    data;
        logic [15:0]                              sw;
        logic [7:0]                               acc_p2;
    } pvcu_regs_t;

    pvcu_regs_t q;
    pvcu_regs_t d;

    // ==========================================================
    // reference decode: {supported, slot}
    function automatic logic [SB:0] slot_of(input logic [7:0] p2);
        logic [4:0] num;
        logic [4:0] m1;
        num = p2[4:0];
        m1  = 5'(num - 5'h01);
        slot_of = {(num != 5'h00) && (num <= 5'(HALF)),
                   p2[pvcu_pkg::P2_SPEC_BIT], m1[SB-2:0]};
    endfunction

    logic [SB:0]   cmd_ref;
    logic [SB:0]   prov_ref;
    logic [SB:0]   acc_ref;
    logic          p_ok;
    logic          blocked;
    logic          match;
    logic [63:0]   nv_pin;
    logic [1:0]    nv_ctr;
    logic          nv_dis;
    logic [1:0]    acc_ctr;
    logic          acc_dis;
    logic          acc_ver;
    logic          acc_grant;
    logic          nv_we;
    logic [SB-1:0] nv_slot;
    logic [1:0]    nv_ctr_w;
    logic          nv_pin_we;
    logic [63:0]   nv_pin_w;
    logic          nv_dis_we;
    logic          ver_set;
    logic          ver_clr;
    logic          req;
    logic          wr_go;
    logic          idle;
    logic [4:0]    addr;
    logic [1:0]    ctr_dec;

    assign cmd_ref  = slot_of(q.p2);
    assign prov_ref = slot_of(i_avs_writedata[7:0]);
    assign acc_ref  = slot_of(q.acc_p2);
    assign p_ok     = (q.p1 == 8'h00) && (q.p2[6:5] == 2'b00);
    assign blocked  = (nv_ctr == 2'h0);
    assign match    = ({q.data[1], q.data[0]} == nv_pin);
    assign ctr_dec  = 2'(nv_ctr - 2'h1);
    assign req      = i_avs_read | i_avs_write;
    assign wr_go    = i_avs_write & ~q.wrq;
    assign idle     = (q.st == ST_IDLE);
    assign addr     = {i_avs_address[4:2], 2'b00};

    // ==========================================================
    // retained store and session status
    pvcu_nv_store #(
        .SLOTS        (SLOTS)
    ) u_nv (
        .i_clk_sys    (i_clk_sys),
        .i_nv_erase_n (i_nv_erase_n),
        .i_we         (nv_we),
        .i_slot       (nv_slot),
        .i_ctr        (nv_ctr_w),
        .i_pin_we     (nv_pin_we),
        .i_pin        (nv_pin_w),
        .i_dis_we     (nv_dis_we),
        .i_dis        (i_avs_writedata[pvcu_pkg::PROV_DIS_BIT]),
        .i_qslot      (acc_ref[SB-1:0]),
        .o_pin        (nv_pin),
        .o_ctr        (nv_ctr),
        .o_dis        (nv_dis),
        .o_qctr       (acc_ctr),
        .o_qdis       (acc_dis)
    );

    pvcu_sec_status #(
        .SLOTS        (SLOTS)
    ) u_sec (
        .i_clk_sys    (i_clk_sys),
        .i_reset_n    (i_reset_n),
        .i_set        (ver_set),
        .i_clr        (ver_clr),
        .i_slot       (nv_slot),
        .i_qslot      (acc_ref[SB-1:0]),
        .i_qdis       (acc_dis),
        .i_qblk       (acc_ctr == 2'h0),
        .o_qver       (acc_ver),
        .o_qgrant     (acc_grant)
    );

    // ==========================================================
    // bus slave and command execution
    always_comb
    begin
        d         = q;
        nv_we     = 1'b0;
        // keep the command's slot after it ends, so its counter stays visible
        nv_slot   = (idle && wr_go && addr == pvcu_pkg::OFF_PROV) ? prov_ref[SB-1:0]
                                                                  : cmd_ref[SB-1:0];
        nv_ctr_w  = pvcu_pkg::CTR_INIT;
        nv_pin_we = 1'b0;
        nv_pin_w  = {q.data[1], q.data[0]};
        nv_dis_we = 1'b0;
        ver_set   = 1'b0;
        ver_clr   = 1'b0;
        // one wait cycle per access, then release for one cycle
        d.wrq     = ~(req & q.wrq);
        if (req && q.wrq)
        begin
            case (addr)
                pvcu_pkg::OFF_STAT: d.rdata = {15'h0000, ~idle, q.sw};
                pvcu_pkg::OFF_ACC:  d.rdata = {26'h0000000, acc_ver, acc_dis,
                                               acc_ctr == 2'h0, acc_grant, acc_ctr};
                pvcu_pkg::OFF_CMD:  d.rdata = {7'h00, q.op, q.lc, q.p1, q.p2};
                // pin data is write only so stored values never leak
                default:            d.rdata = 32'h00000000;
            endcase
        end
        if (wr_go && idle)
        begin
            for (int k = 0; k < pvcu_pkg::DATA_WORDS; k++)
            begin
                if (addr == 5'(pvcu_pkg::OFF_DATA0 + 4 * k))
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (i_avs_byteenable[b])
                            d.data[k][8*b +: 8] = i_avs_writedata[8*b +: 8];
                    end
                end
            end
            if (addr == pvcu_pkg::OFF_CMD)
            begin
                d.p2 = i_avs_writedata[pvcu_pkg::CMD_P2_LSB +: 8];
                d.p1 = i_avs_writedata[pvcu_pkg::CMD_P1_LSB +: 8];
                d.lc = i_avs_writedata[pvcu_pkg::CMD_LC_LSB +: 8];
                d.op = i_avs_writedata[pvcu_pkg::CMD_OP_BIT];
                d.st = ST_EXEC;
            end
            if (addr == pvcu_pkg::OFF_PROV && prov_ref[SB])
            begin
                nv_we     = 1'b1;
                nv_pin_we = 1'b1;
                nv_dis_we = 1'b1;
                ver_clr   = 1'b1;
            end
        end
        if (wr_go && addr == pvcu_pkg::OFF_ACC)
            d.acc_p2 = i_avs_writedata[7:0];
        if (q.st == ST_EXEC)
        begin
            d.st = ST_IDLE;
            if (!p_ok)
                d.sw = pvcu_pkg::SW_BAD_P1P2;
            else if (!cmd_ref[SB])
                d.sw = pvcu_pkg::SW_NO_REF;
            else if (q.op == pvcu_pkg::OP_VERIFY && q.lc == pvcu_pkg::LC_QUERY)
                d.sw = {pvcu_pkg::SW_RETRY_HI, 2'b00, nv_ctr};
            else if (q.lc != (q.op ? pvcu_pkg::LC_CHANGE : pvcu_pkg::LC_VERIFY))
                d.sw = pvcu_pkg::SW_BAD_LC;
            else if (blocked)
                d.sw = pvcu_pkg::SW_BLOCKED;
            else if (nv_dis)
                d.sw = pvcu_pkg::SW_DISABLED;
            else if (match)
            begin
                nv_we     = 1'b1;
                nv_pin_we = q.op;
                nv_pin_w  = {q.data[3], q.data[2]};
                ver_set   = 1'b1;
                d.sw      = pvcu_pkg::SW_OK;
            end
            else
            begin
                nv_we    = 1'b1;
                nv_ctr_w = ctr_dec;
                ver_clr  = (ctr_dec == 2'h0);
                d.sw     = {pvcu_pkg::SW_RETRY_HI, 2'b00, ctr_dec};
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            q.st     <= ST_IDLE;
            q.wrq    <= 1'b1;
            q.rdata  <= 32'h00000000;
            q.p1     <= 8'h00;
            q.p2     <= 8'h00;
            q.lc     <= 8'h00;
            q.op     <= pvcu_pkg::OP_VERIFY;
            q.data   <= '0;
            q.sw     <= pvcu_pkg::SW_RESET;
            q.acc_p2 <= 8'h00;
        end
        else
            q <= d;
    end

    assign o_avs_readdata    = q.rdata;
    assign o_avs_waitrequest = q.wrq;

    // ==========================================================
    // checks
    logic exec_ok;
    logic ver_go;
    logic chg_go;

    assign exec_ok = (q.st == ST_EXEC) && p_ok && cmd_ref[SB];
    assign ver_go  = exec_ok && q.op == pvcu_pkg::OP_VERIFY
                     && q.lc == pvcu_pkg::LC_VERIFY && !blocked && !nv_dis;
    assign chg_go  = exec_ok && q.op == pvcu_pkg::OP_CHANGE
                     && q.lc == pvcu_pkg::LC_CHANGE && !blocked && !nv_dis;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    good_reload_a: assert property (
        ver_go && match |=> nv_ctr == 2'h3 && q.sw == 16'h9000)
        else $error("counter not reloaded after correct pin");

    miss_dec_a: assert property (
        (ver_go || chg_go) && !match |=> nv_ctr == 2'($past(nv_ctr) - 2'h1))
        else $error("counter not decremented after wrong pin");

    first_miss_a: assert property (
        ver_go && !match && nv_ctr == 2'h3 |=> q.sw == 16'h63C2)
        else $error("first wrong pin status wrong");

    second_miss_a: assert property (
        ver_go && !match && nv_ctr == 2'h2 |=> q.sw == 16'h63C1)
        else $error("second wrong pin status wrong");

    third_block_a: assert property (
        ver_go && !match && nv_ctr == 2'h1
        |=> q.sw == 16'h63C0 && blocked && (acc_ref != cmd_ref || !acc_ver))
        else $error("third wrong pin did not block");

    blk_reject_a: assert property (
        exec_ok && q.op == pvcu_pkg::OP_VERIFY && q.lc == pvcu_pkg::LC_VERIFY
        && blocked |=> q.sw == 16'h6983 && $stable(nv_ctr))
        else $error("blocked pin not rejected");

    ctr_query_a: assert property (
        exec_ok && q.op == pvcu_pkg::OP_VERIFY && q.lc == pvcu_pkg::LC_QUERY
        |=> q.sw == {12'h63C, 2'b00, $past(nv_ctr)} && $stable(nv_ctr))
        else $error("retry counter query wrong");

    change_adopt_a: assert property (
        chg_go && match
        |=> nv_pin == $past({q.data[3], q.data[2]}) && nv_ctr == 2'h3)
        else $error("new pin not adopted");

    change_keep_a: assert property (
        chg_go && !match |=> $stable(nv_pin))
        else $error("pin changed on mismatch");

    bad_param_a: assert property (
        (q.st == ST_EXEC) && !p_ok |=> q.sw == 16'h6B00 && $stable(nv_ctr))
        else $error("reserved p1/p2 not refused");

    bus_ack_a: assert property (
        req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest handshake broken");
endmodule
`default_nettype wire

// >>> pvcu_terminal.sv
// terminal model: issues pin commands through the avalon-mm slave port
`default_nettype none
module pvcu_terminal (
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_avs_readdata,
    input  wire logic        i_avs_waitrequest,
    output logic      [4:0]  o_avs_address,
    output logic             o_avs_read,
    output logic             o_avs_write,
    output logic      [31:0] o_avs_writedata,
    output logic      [3:0]  o_avs_byteenable
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_avs_address    = 5'h00;
        o_avs_read       = 1'b0;
        o_avs_write      = 1'b0;
        o_avs_writedata  = 32'h00000000;
        o_avs_byteenable = 4'hF;
    end

    // ==========================================================
    // one bus cycle, entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        o_avs_address   <= a;
        o_avs_writedata <= d;
        o_avs_write     <= wr;
        o_avs_read      <= !wr;
        @(posedge i_clk_sys);
        while (i_avs_waitrequest !== 1'b0)
            @(posedge i_clk_sys);
        q = i_avs_readdata;
        o_avs_write     <= 1'b0;
        o_avs_read      <= 1'b0;
        // released lines must not look like a held request
        o_avs_writedata <= ~d;
        o_avs_address   <= ~a;
        // one idle edge so no strobe is assigned twice in a step
        @(posedge i_clk_sys);
    endtask

    // ==========================================================
    // full command: data words, command word, poll until idle
    task automatic apdu(input logic op, input logic [7:0] p1, p2, lc,
                        input logic [63:0] oldp, newp, output logic [15:0] sw);
        logic [31:0] r;
        bus(1'b1, pvcu_pkg::OFF_DATA0, oldp[31:0], r);
        bus(1'b1, 5'h0C, oldp[63:32], r);
        bus(1'b1, 5'h10, newp[31:0], r);
        bus(1'b1, 5'h14, newp[63:32], r);
        bus(1'b1, pvcu_pkg::OFF_CMD, {7'h00, op, lc, p1, p2}, r);
        do
            bus(1'b0, pvcu_pkg::OFF_STAT, 32'h00000000, r);
        while (r[pvcu_pkg::STAT_BUSY] !== 1'b0);
        sw = r[15:0];
    endtask
endmodule
`default_nettype wire

// >>> pvcu_top_bench.sv
// self-checking bench for the pin verify/change unit
`default_nettype none
module pvcu_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [63:0] PIN_A = 64'hFFFFFFFF34333231;
    localparam logic [63:0] PIN_B = 64'hFFFFFFFF38373635;
    localparam logic [63:0] PIN_C = 64'hFFFF303030303030;
    localparam logic [63:0] BAD   = 64'hFFFFFFFF39393939;

    logic        clk_sys    = 1'b0;
    logic        reset_n    = 1'b0;
    logic        nv_erase_n = 1'b0;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          num_errors = 0;
    int          num_checks = 0;
    // p1, p2, expected status word
    logic [31:0] bad_tab [5] = '{32'h01826B00, 32'h00216B00, 32'h00416B00,
                                 32'h00006A88, 32'h001F6A88};

    always #5 clk_sys = ~clk_sys;

    pvcu_top i_dut (
        .i_clk_sys         (clk_sys),
        .i_reset_n         (reset_n),
        .i_nv_erase_n      (nv_erase_n),
        .i_avs_address     (avs_address),
        .i_avs_read        (avs_read),
        .i_avs_write       (avs_write),
        .i_avs_writedata   (avs_writedata),
        .i_avs_byteenable  (avs_byteenable),
        .o_avs_readdata    (avs_readdata),
        .o_avs_waitrequest (avs_waitrequest)
    );

    pvcu_terminal i_term (
        .i_clk_sys         (clk_sys),
        .i_avs_readdata    (avs_readdata),
        .i_avs_waitrequest (avs_waitrequest),
        .o_avs_address     (avs_address),
        .o_avs_read        (avs_read),
        .o_avs_write       (avs_write),
        .o_avs_writedata   (avs_writedata),
        .o_avs_byteenable  (avs_byteenable)
    );

    // ==========================================================
    // compare and report
    task automatic check_sw(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: status %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic check_acc(input logic [5:0] got, input logic [5:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: access %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // command helpers
    task automatic cmd(input logic op, input logic [7:0] p1, p2, lc,
                       input logic [63:0] oldp, newp, input logic [15:0] exp);
        logic [15:0] sw;
        i_term.apdu(op, p1, p2, lc, oldp, newp, sw);
        check_sw(sw, exp);
    endtask

    task automatic ver(input logic [7:0] p2, input logic [63:0] pin, input logic [15:0] exp);
        cmd(pvcu_pkg::OP_VERIFY, 8'h00, p2, pvcu_pkg::LC_VERIFY, pin, ~pin, exp);
    endtask

    task automatic qry(input logic [7:0] p2, input logic [15:0] exp);
        cmd(pvcu_pkg::OP_VERIFY, 8'h00, p2, pvcu_pkg::LC_QUERY, 64'h0, 64'h0, exp);
    endtask

    task automatic chg(input logic [7:0] p2, lc, input logic [63:0] o, n,
                       input logic [15:0] exp);
        cmd(pvcu_pkg::OP_CHANGE, 8'h00, p2, lc, o, n, exp);
    endtask

    task automatic prov(input logic [7:0] p2, input logic [63:0] pin, input logic dis);
        logic [31:0] r;
        i_term.bus(1'b1, pvcu_pkg::OFF_DATA0, pin[31:0], r);
        i_term.bus(1'b1, 5'h0C, pin[63:32], r);
        i_term.bus(1'b1, pvcu_pkg::OFF_PROV, {23'h000000, dis, p2}, r);
    endtask

    // access bits: verified, disabled, blocked, granted, counter
    task automatic acc(input logic [7:0] p2, input logic [5:0] exp);
        logic [31:0] r;
        i_term.bus(1'b1, pvcu_pkg::OFF_ACC, {24'h000000, p2}, r);
        i_term.bus(1'b0, pvcu_pkg::OFF_ACC, 32'h00000000, r);
        check_acc(r[5:0], exp);
    endtask

    // session reset only: the retained store must keep its state
    task automatic sess_reset;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
    endtask

    // ==========================================================
    // tests
    initial
    begin
        logic [31:0] rd;
        repeat (10) @(posedge clk_sys);
        reset_n    <= 1'b1;
        nv_erase_n <= 1'b1;
        @(posedge clk_sys);

        prov(8'h01, PIN_A, 1'b0);
        qry(8'h01, 16'h63C3);
        acc(8'h01, 6'h03);
        ver(8'h01, BAD, 16'h63C2);
        ver(8'h01, BAD, 16'h63C1);
        ver(8'h01, PIN_A, 16'h9000);
        qry(8'h01, 16'h63C3);
        acc(8'h01, 6'h27);
        $display("test verify done");

        ver(8'h01, BAD, 16'h63C2);
        sess_reset;
        qry(8'h01, 16'h63C2);
        acc(8'h01, 6'h02);
        ver(8'h01, BAD, 16'h63C1);
        ver(8'h01, BAD, 16'h63C0);
        acc(8'h01, 6'h08);
        ver(8'h01, PIN_A, 16'h6983);
        qry(8'h01, 16'h63C0);
        chg(8'h01, 8'h10, PIN_A, PIN_B, 16'h6983);
        $display("test block done");

        prov(8'h82, PIN_B, 1'b0);
        chg(8'h82, 8'h08, PIN_B, PIN_C, 16'h6700);
        chg(8'h82, 8'h10, BAD, PIN_C, 16'h63C2);
        chg(8'h82, 8'h10, PIN_B, PIN_C, 16'h9000);
        ver(8'h82, PIN_B, 16'h63C2);
        ver(8'h82, PIN_C, 16'h9000);
        qry(8'h82, 16'h63C3);
        i_term.bus(1'b0, pvcu_pkg::OFF_CMD, 32'h00000000, rd);
        check_reg(rd, 32'h00000082);
        $display("test change done");

        prov(8'h03, PIN_A, 1'b1);
        ver(8'h03, PIN_A, 16'h6984);
        qry(8'h03, 16'h63C3);
        acc(8'h03, 6'h17);
        chg(8'h03, 8'h10, PIN_A, PIN_B, 16'h6984);
        $display("test disabled done");

        for (int i = 0; i < 5; i++)
            for (int o = 0; o < 2; o++)
                cmd(o[0], bad_tab[i][31:24], bad_tab[i][23:16], o[0] ? 8'h10 : 8'h08,
                    BAD, PIN_C, bad_tab[i][15:0]);
        qry(8'h82, 16'h63C3);
        qry(8'h01, 16'h63C0);
        $display("test coding done");

        final_report;
    end

    // the tests need well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report;
    end
endmodule
`default_nettype wire
